// *** core/lcs_pkg.sv ***
// Package for the charge sequencer: timing counts, carriers and rule notes
// Functional notes
// - After power-up show red, green, yellow, then all indicators off.
// - Each power-up indicator step lasts 500 ms of oscillator time.
// - After power-up stay idle until the active-low enable shows a pack.
// - On enable wait a 500 ms settling delay before verifying connection.
// - During verification limit current to trickle and release voltage clamp.
// - If sense still reads open after 70 ms, end attempt, output off.
// - When no battery is found, do not charge and keep indicators dark.
// - After connection is confirmed, check for short before any charging.
// - Below-1V still set after 384 oscillator cycles: stop, flash yellow.
// - With no fault, enter trickle mode and light the red indicator.
// - Each charge cycle starts at 10 percent current until above min voltage.
// - Not above 2.8 V within one eighth of time limit: stop, flash yellow.
// - Past the minimum fast-charge voltage, turn the pass element fully on.
// - Constant current continues until the regulation voltage is reached.
// - At regulation voltage switch to constant voltage while current tapers.
// - Outside verification the output voltage is clamped to 4.2 V.
// - Current at end-of-charge level: indicator goes from red to green.
// - Charge time limit expiry also gives the end-of-charge indication.
// - After end, at recharge threshold, recharge to 4.2 V and low current.
// - Recharge repeats until enable is removed, which returns to idle.
// - While ambient temperature is out of range, do not charge.
// - Select the high ambient limit while charging, the low one otherwise.
// - Die temperature at 100 C requests reduced charge current.
package lcs_pkg;

	// Oscillator period in microseconds (nominal capacitor setting)
	localparam int unsigned OSC_PERIOD_US   = 3000;
	localparam int unsigned LED_STEP_MS     = 500;
	localparam int unsigned SETTLE_MS       = 500;
	localparam int unsigned VERIFY_MS       = 70;
	localparam int unsigned SHORT_TICKS     = 384;
	localparam int unsigned EOC_QUAL_TICKS  = 3;
	localparam int unsigned FLASH_HALF_TICKS = 100;
	// Charge time limit in ticks; default arbitrary, set from timing capacitor
	localparam int unsigned TIMEOUT_TICKS   = 24'h04CE00;
	localparam int unsigned TRICKLE_DIV_SH  = 3;

	localparam int unsigned CNT_W = 24;

	localparam logic [CNT_W-1:0] LED_STEP_TICKS =
		CNT_W'((LED_STEP_MS * 1000 + OSC_PERIOD_US - 1) / OSC_PERIOD_US);
	localparam logic [CNT_W-1:0] SETTLE_TICKS =
		CNT_W'((SETTLE_MS * 1000 + OSC_PERIOD_US - 1) / OSC_PERIOD_US);
	localparam logic [CNT_W-1:0] VERIFY_TICKS =
		CNT_W'((VERIFY_MS * 1000 + OSC_PERIOD_US - 1) / OSC_PERIOD_US);

	localparam int unsigned FLAG_W = 9;

	// Analog comparator flags
	typedef struct packed {
		logic open_sense;   // Battery sense reads open (near input supply)
		logic below_1v;     // Battery below short-circuit threshold
		logic above_fast_charge_min_voltage;   // Above fast_charge_min_voltage
		logic at_vreg;      // At charge_regulation_voltage
		logic below_eoc;    // Current below eoc_current_level
		logic at_recharge;  // Battery above recharge threshold
		logic amb_ok;       // Ambient temperature within selected limit
		logic die_hot;      // Die at foldback temperature
		logic supply_ok;    // input_supply_voltage above battery
	} lcs_flags_s;

	// Commands to the analog regulation loop
	typedef struct packed {
		logic out_en;       // Pass element enabled
		logic trickle;      // precondition_current level
		logic full_on;      // Pass element fully on (constant current)
		logic cv_mode;      // Hold constant voltage
		logic vclamp;       // Clamp output to 4.2 V
		logic foldback;     // Reduced current request
		logic amb_high_sel; // Select the higher ambient limit
	} lcs_cmd_s;

	typedef struct packed {
		logic red;
		logic grn;
	} lcs_led_s;

endpackage : lcs_pkg

// *** core/lcs_sync.sv ***
// Two-stage synchroniser for the comparator flags
`timescale 1ns/10ps
module lcs_sync
	import lcs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	// Flags
	input  wire lcs_flags_s  async_i,
	output lcs_flags_s       sync_o
);

	lcs_flags_s meta;

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			meta   <= '0;
			sync_o <= '0;
		end
		else if (ce_i)
		begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule : lcs_sync

// *** core/lcs_sequencer.sv ***
// Charge sequencer state machine for a single-cell charger
`timescale 1ns/10ps
module lcs_sequencer
	import lcs_pkg::*;
#(
	parameter logic [CNT_W-1:0] TIMEOUT_LIMIT = CNT_W'(TIMEOUT_TICKS)
)
(
	// Clock, reset, enable
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        ce_i,
	// Oscillator tick, one cycle per oscillator period
	input  wire logic        osc_tick_i,
	// Battery-present enable, active low
	input  wire logic        enable_n_i,
	// Comparator flags
	input  wire lcs_flags_s  flags_i,
	// Regulation loop commands
	output lcs_cmd_s         cmd_o,
	// Indicator drive (open drain: enable high sinks the LED)
	output logic             red_o,
	output logic             red_oe_o,
	output logic             grn_o,
	output logic             grn_oe_o,
	// Status
	output logic             fault_o,
	output logic             charging_o
);

	typedef enum logic [12:0] {
		ST_LED_RED  = 13'h0001,
		ST_LED_GRN  = 13'h0002,
		ST_LED_YEL  = 13'h0004,
		ST_IDLE     = 13'h0008,
		ST_SETTLE   = 13'h0010,
		ST_VERIFY   = 13'h0020,
		ST_SHORT    = 13'h0040,
		ST_TRICKLE  = 13'h0080,
		ST_CC       = 13'h0100,
		ST_CV       = 13'h0200,
		ST_DONE     = 13'h0400,
		ST_OPEN     = 13'h0800,
		ST_FAULT    = 13'h1000
	} lcs_state_e;

	lcs_state_e       state;
	lcs_state_e       next_state;
	lcs_flags_s       fl;
	logic [CNT_W-1:0] step_cnt;
	logic [CNT_W-1:0] chg_cnt;
	logic [2:0]       eoc_cnt;
	logic [7:0]       flash_cnt;
	logic             flash_on;
	logic             en_now;
	logic             chg_state;
	logic             restart;

	lcs_sync u_sync
	(
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.ce_i    (ce_i),
		.async_i (flags_i),
		.sync_o  (fl)
	);

	function automatic logic reached(input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] lim);
		reached = (cnt >= lim - CNT_W'(1));
	endfunction : reached

	assign en_now    = ~enable_n_i;
	assign chg_state = (state == ST_TRICKLE) || (state == ST_CC)
		|| (state == ST_CV);
	assign restart   = (next_state != state);

	// Next-state decision
	always_comb
	begin
		next_state = state;
		case (state)
			ST_LED_RED:
				if (osc_tick_i && reached(step_cnt, LED_STEP_TICKS))
					next_state = ST_LED_GRN;
			ST_LED_GRN:
				if (osc_tick_i && reached(step_cnt, LED_STEP_TICKS))
					next_state = ST_LED_YEL;
			ST_LED_YEL:
				if (osc_tick_i && reached(step_cnt, LED_STEP_TICKS))
					next_state = ST_IDLE;
			ST_IDLE:
				if (en_now && fl.supply_ok && fl.amb_ok)
					next_state = ST_SETTLE;
			ST_SETTLE:
				if (osc_tick_i && reached(step_cnt, SETTLE_TICKS))
					next_state = ST_VERIFY;
			ST_VERIFY:
				if (osc_tick_i && reached(step_cnt, VERIFY_TICKS))
					next_state = fl.open_sense ? ST_OPEN
						: ST_SHORT;
			ST_SHORT:
				if (osc_tick_i
					&& reached(step_cnt, CNT_W'(SHORT_TICKS)))
					next_state = fl.below_1v ? ST_FAULT
						: ST_TRICKLE;
			ST_TRICKLE:
				if (fl.above_fast_charge_min_voltage)
					next_state = ST_CC;
				else if (osc_tick_i && reached(chg_cnt,
					TIMEOUT_LIMIT >> TRICKLE_DIV_SH))
					next_state = ST_FAULT;
			ST_CC:
				if (osc_tick_i && reached(chg_cnt, TIMEOUT_LIMIT))
					next_state = ST_DONE;
				else if (fl.at_vreg)
					next_state = ST_CV;
			ST_CV:
				if (osc_tick_i && reached(chg_cnt, TIMEOUT_LIMIT))
					next_state = ST_DONE;
				else if (eoc_cnt >= 3'(EOC_QUAL_TICKS))
					next_state = ST_DONE;
			// Recharge only once the cell has sagged to the threshold
			ST_DONE:
				if (!fl.at_recharge && fl.amb_ok)
					next_state = ST_TRICKLE;
			ST_OPEN,
			ST_FAULT:
				next_state = state;
			default:
				next_state = ST_IDLE;
		endcase
		// Ambient out of range pauses charging back to idle
		if (chg_state && !fl.amb_ok)
			next_state = ST_IDLE;
		// Pack removal returns every post-idle state to idle
		if (!en_now && (state != ST_LED_RED) && (state != ST_LED_GRN)
			&& (state != ST_LED_YEL))
			next_state = ST_IDLE;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			state <= ST_LED_RED;
		else if (ce_i)
			state <= next_state;
	end

	// Step counter restarts on every state change
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			step_cnt <= '0;
		else if (ce_i)
		begin
			if (restart)
				step_cnt <= '0;
			else if (osc_tick_i)
				step_cnt <= step_cnt + CNT_W'(1);
		end
	end

	// Charge time counter: cleared at a new attempt or recharge
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			chg_cnt <= '0;
		else if (ce_i)
		begin
			if (!chg_state)
				chg_cnt <= '0;
			else if (osc_tick_i && chg_cnt != '1)
				chg_cnt <= chg_cnt + CNT_W'(1);
		end
	end

	// End-of-charge qualification over several oscillator ticks
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			eoc_cnt <= '0;
		else if (ce_i)
		begin
			if (state != ST_CV || !fl.below_eoc || !fl.at_recharge)
				eoc_cnt <= '0;
			else if (osc_tick_i && eoc_cnt != 3'h7)
				eoc_cnt <= eoc_cnt + 3'h1;
		end
	end

	// Fault flash timer
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			flash_cnt <= '0;
			flash_on  <= 1'b0;
		end
		else if (ce_i && osc_tick_i)
		begin
			if (flash_cnt >= 8'(FLASH_HALF_TICKS - 1))
			begin
				flash_cnt <= '0;
				flash_on  <= ~flash_on;
			end
			else
				flash_cnt <= flash_cnt + 8'h01;
		end
	end

	// Indicator and command outputs, registered
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			red_oe_o   <= 1'b0;
			grn_oe_o   <= 1'b0;
			cmd_o      <= '0;
			fault_o    <= 1'b0;
			charging_o <= 1'b0;
		end
		else if (ce_i)
		begin
			case (next_state)
				ST_LED_RED: {red_oe_o, grn_oe_o} <= 2'h2;
				ST_LED_GRN: {red_oe_o, grn_oe_o} <= 2'h1;
				ST_LED_YEL: {red_oe_o, grn_oe_o} <= 2'h3;
				ST_SHORT,
				ST_TRICKLE,
				ST_CC,
				ST_CV:      {red_oe_o, grn_oe_o} <= 2'h2;
				ST_DONE:    {red_oe_o, grn_oe_o} <= 2'h1;
				ST_FAULT:   {red_oe_o, grn_oe_o}
					<= {flash_on, flash_on};
				ST_OPEN:    {red_oe_o, grn_oe_o} <= 2'h0;
				default:    {red_oe_o, grn_oe_o} <= 2'h0;
			endcase
			cmd_o.out_en  <= (next_state == ST_VERIFY)
				|| (next_state == ST_SHORT) || (next_state == ST_TRICKLE)
				|| (next_state == ST_CC) || (next_state == ST_CV);
			cmd_o.trickle <= (next_state == ST_VERIFY)
				|| (next_state == ST_SHORT)
				|| (next_state == ST_TRICKLE);
			cmd_o.full_on <= (next_state == ST_CC)
				|| (next_state == ST_CV);
			cmd_o.cv_mode <= (next_state == ST_CV);
			cmd_o.vclamp  <= (next_state != ST_VERIFY);
			cmd_o.foldback <= fl.die_hot;
			cmd_o.amb_high_sel <= (next_state == ST_TRICKLE)
				|| (next_state == ST_CC) || (next_state == ST_CV);
			fault_o    <= (next_state == ST_FAULT)
				|| (next_state == ST_OPEN);
			charging_o <= (next_state == ST_TRICKLE)
				|| (next_state == ST_CC) || (next_state == ST_CV);
		end
	end

	// Open-drain pins only ever sink
	assign red_o = 1'b0;
	assign grn_o = 1'b0;

endmodule : lcs_sequencer

// *** sim/lcs_battery_model.sv ***
// Behavioural cell and adapter model for the charge sequencer bench
`timescale 1ns/10ps
module lcs_battery_model
	import lcs_pkg::*;
(
	// Clock, tick and loop commands
	input  wire logic       clk_i,
	input  wire logic       osc_tick_i,
	input  wire lcs_cmd_s   cmd_i,
	// Scenario controls
	input  wire logic       present_i,
	input  wire logic       short_i,
	input  wire logic       stuck_i,
	input  wire logic       hot_i,
	input  wire logic       amb_i,
	// Comparator flags
	output lcs_flags_s      flags_o
);
	int v = 5;
	int cv = 0;
	// Cell voltage in steps; an idle cell sags, a stuck or shorted one never rises
	always @(posedge clk_i)
		if (!present_i)
			v <= 5;
		else if (osc_tick_i && !cmd_i.out_en)
			v <= (v > 5) ? v - 1 : v;
		else if (osc_tick_i && !stuck_i && !short_i && v < 20)
			v <= v + 1 + int'(cmd_i.full_on);
	// Current tapers a few ticks after constant voltage starts
	always @(posedge clk_i)
		if (osc_tick_i)
			cv <= cmd_i.cv_mode ? cv + 1 : 0;
	assign flags_o = '{open_sense: !present_i, below_1v: short_i,
		above_fast_charge_min_voltage: v >= 10, at_vreg: v >= 20, below_eoc: cv >= 5,
		at_recharge: v >= 18, amb_ok: amb_i, die_hot: hot_i,
		supply_ok: 1'h1};
endmodule : lcs_battery_model

// *** sim/lcs_sequencer_assertions.sv ***
// Port-level checks bound to the charge sequencer
`timescale 1ns/10ps
module lcs_sequencer_assertions
	import lcs_pkg::*;
#(
	parameter logic [CNT_W-1:0] TIMEOUT_LIMIT = CNT_W'(TIMEOUT_TICKS)
)
(
	// Clock and inputs
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       enable_n_i,
	input  wire lcs_flags_s flags_i,
	// Outputs
	input  wire lcs_cmd_s   cmd_o,
	input  wire logic       red_oe_o,
	input  wire logic       grn_oe_o,
	input  wire logic       fault_o,
	input  wire logic       charging_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_amb_low;
		!flags_i.amb_ok [*5];
	endsequence
	sequence s_plugged;
		!enable_n_i [*4];
	endsequence
	chk_amb_stop: assert property (s_amb_low |=> !charging_o)
		else $error("charging with ambient out of range");
	chk_fold_follow: assert property (
		$rose(flags_i.die_hot) |-> ##[1:4] cmd_o.foldback)
		else $error("no foldback request");
	chk_fault_holds: assert property (
		fault_o ##0 s_plugged |=> fault_o)
		else $error("fault cleared with pack still present");
	chk_startup_red: assert property (
		$fell(srst_i) |=> red_oe_o && !grn_oe_o)
		else $error("no red after reset");
	chk_verify_open: assert property (
		!cmd_o.vclamp && !$past(srst_i) |-> cmd_o.out_en && cmd_o.trickle)
		else $error("voltage clamp off outside verification");
	chk_full_path: assert property (
		cmd_o.full_on |-> charging_o && !cmd_o.trickle && cmd_o.vclamp)
		else $error("full current outside charging");
	chk_fault_idle: assert property (
		fault_o |-> !charging_o && !cmd_o.out_en)
		else $error("output on during fault");
	chk_amb_select: assert property (
		cmd_o.amb_high_sel == charging_o)
		else $error("ambient limit select wrong");
	chk_trickle_red: assert property (
		charging_o && cmd_o.trickle |-> red_oe_o && !grn_oe_o)
		else $error("trickle without red");
endmodule : lcs_sequencer_assertions
bind lcs_sequencer lcs_sequencer_assertions #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT))
	u_lcs_sequencer_assertions (.clk_i, .srst_i, .enable_n_i, .flags_i,
	.cmd_o, .red_oe_o, .grn_oe_o, .fault_o, .charging_o);

// *** sim/test_lcs_sequencer.sv ***
// Self-checking testbench for the charge sequencer
`timescale 1ns/10ps
module test_lcs_sequencer;
	import lcs_pkg::*;
	logic       clk_i = 1'h0;
	logic       srst_i = 1'h1;
	logic       osc_tick_i = 1'h0;
	logic       enable_n_i = 1'h1;
	logic       present = 1'h0;
	logic       short_c = 1'h0;
	logic       stuck = 1'h0;
	logic       hot = 1'h0;
	logic       amb = 1'h1;
	lcs_flags_s flags_i;
	lcs_cmd_s   cmd_o;
	logic       red_o, red_oe_o, grn_o, grn_oe_o, fault_o, charging_o;
	int         err_count = 0;
	int         compares = 0;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) osc_tick_i <= ~osc_tick_i;

	lcs_battery_model u_lcs_battery_model (.clk_i, .osc_tick_i,
		.cmd_i(cmd_o), .present_i(present), .short_i(short_c),
		.stuck_i(stuck), .hot_i(hot), .amb_i(amb), .flags_o(flags_i));
	lcs_sequencer #(.TIMEOUT_LIMIT(24'h000040)) u_lcs_sequencer (.clk_i,
		.srst_i, .ce_i(1'h1), .osc_tick_i, .enable_n_i, .flags_i, .cmd_o,
		.red_o, .red_oe_o, .grn_o, .grn_oe_o, .fault_o, .charging_o);

	task report_and_stop;
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task ticks(input int n);
		repeat (2 * n) @(negedge clk_i);
	endtask : ticks
	function automatic logic sel(input int k);
		case (k)
			0: return fault_o;
			1: return charging_o;
			2: return grn_oe_o;
			3: return cmd_o.full_on;
			default: return cmd_o.cv_mode;
		endcase
	endfunction : sel
	// Bounded wait on one status output; running out ends the run
	task wait_hi(input int k, input int lim);
		int i;
		for (i = 0; i < lim && sel(k) !== 1'h1; i++)
			@(negedge clk_i);
		check("wait", 8'(sel(k)), 8'h01);
		if (sel(k) !== 1'h1)
			report_and_stop();
	endtask : wait_hi
	task plug(input logic p, input logic s, input logic k);
		@(posedge clk_i);
		present <= p;
		short_c <= s;
		stuck <= k;
		enable_n_i <= 1'h0;
		ticks(100);
		check("settle", 8'(cmd_o.out_en), 8'h00);
		ticks(80);
		check("verify", {cmd_o.out_en, cmd_o.trickle,
			cmd_o.vclamp}, 8'h06);
	endtask : plug
	task unplug;
		@(posedge clk_i);
		enable_n_i <= 1'h1;
		ticks(4);
		check("idle", {fault_o, charging_o, cmd_o.out_en}, 8'h00);
	endtask : unplug
	task test_leds;
		ticks(80);
		check("red", {red_oe_o, grn_oe_o}, 8'h02);
		ticks(167);
		check("green", {red_oe_o, grn_oe_o}, 8'h01);
		ticks(167);
		check("yellow", {red_oe_o, grn_oe_o}, 8'h03);
		ticks(167);
		check("off", {red_oe_o, grn_oe_o, red_o, grn_o}, 8'h00);
		$display("test leds done");
	endtask : test_leds
	task test_open;
		plug(1'h0, 1'h0, 1'h0);
		ticks(30);
		check("open", {fault_o, red_oe_o, grn_oe_o,
			cmd_o.out_en}, 8'h08);
		ticks(50);
		check("open held", 8'(fault_o), 8'h01);
		unplug();
		$display("test open done");
	endtask : test_open
	task test_fault(input logic s, input logic k);
		plug(1'h1, s, k);
		ticks(300);
		check("early fault", 8'(fault_o), 8'h00);
		wait_hi(0, 400);
		check("flash", {red_oe_o ^ grn_oe_o, charging_o}, 8'h00);
		unplug();
		$display("test fault done");
	endtask : test_fault
	task test_charge;
		plug(1'h1, 1'h0, 1'h0);
		wait_hi(1, 1000);
		check("trickle", {cmd_o.trickle, red_oe_o, grn_oe_o,
			cmd_o.amb_high_sel}, 8'h0D);
		wait_hi(3, 100);
		check("cc", {cmd_o.trickle, cmd_o.vclamp}, 8'h01);
		wait_hi(4, 100);
		check("cv", 8'(charging_o), 8'h01);
		wait_hi(2, 100);
		check("eoc", {red_oe_o, charging_o}, 8'h00);
		ticks(1);
		check("eoc held", 8'(grn_oe_o), 8'h01);
		wait_hi(1, 200);
		@(posedge clk_i);
		hot <= 1'h1;
		amb <= 1'h0;
		ticks(4);
		check("amb", {charging_o, cmd_o.out_en,
			cmd_o.foldback}, 8'h01);
		@(posedge clk_i);
		hot <= 1'h0;
		amb <= 1'h1;
		unplug();
		$display("test charge done");
	endtask : test_charge

	initial
	begin
		repeat (4) @(posedge clk_i);
		srst_i <= 1'h0;
		test_leds();
		test_open();
		test_fault(1'h1, 1'h0);
		test_fault(1'h0, 1'h1);
		test_charge();
		report_and_stop();
	end
endmodule : test_lcs_sequencer
